// ==== hw/flash_id_mode_and_burst_config.sv ====
// identification mode, command decode and burst address logic of a banked flash
// assumes host strobes are synchronous to clock; array data arrive combinationally
`timescale 1ns/1ps
`default_nettype none
`include "flash_id_params.svh"

module flash_id_mode_and_burst_config #(
	parameter int ADDR_W = 24,
	parameter int BANK_W = 4,
	parameter int SECTOR_W = 8,
	parameter logic [15:0] MAKER_CODE = 16'h00a5,
	parameter logic [15:0] PART_CODE_A = 16'h1a2b,
	parameter logic [15:0] PART_CODE_B = 16'h1c2d,
	parameter logic [15:0] PART_CODE_C = 16'h1e00
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic addr_valid_n,
	input wire logic ce_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic [ADDR_W-17:0] addr_hi,
	input wire logic [15:0] adq_in,
	output logic [15:0] adq_out,
	output logic adq_oe_n,
	output logic [ADDR_W-1:0] array_addr,
	input wire logic [15:0] array_rdata,
	input wire logic embedded_busy,
	input wire logic factory_lock,
	input wire logic customer_lock,
	input wire logic lock_wr_en,
	input wire logic [SECTOR_W-1:0] lock_wr_sector,
	input wire logic lock_wr_value,
	output logic id_mode,
	output logic [BANK_W-1:0] id_bank,
	output logic cfg_read_mode,
	output logic [15:0] config_word_zero,
	output logic [15:0] config_word_one
);

	// command decode state
	flash_id_pkg::cmd_state_t state_q;
	flash_id_pkg::cmd_state_t state_d;
	logic id_active_q;
	logic id_active_d;
	logic [BANK_W-1:0] id_bank_q;
	logic [BANK_W-1:0] id_bank_d;
	logic cfg_read_q;
	logic cfg_read_d;
	logic [15:0] cfg0_q;
	logic [15:0] cfg0_d;
	logic [15:0] cfg1_q;
	logic [15:0] cfg1_d;
	logic we_n_q;

	// read path state
	logic [ADDR_W-1:0] addr_q;
	logic [ADDR_W-1:0] addr_d;
	logic [15:0] adq_out_q;
	logic [15:0] adq_out_d;
	logic adq_oe_n_q;
	logic adq_oe_n_d;

	logic wr_ev;
	logic rd_cycle;
	logic [7:0] wr_cmd;
	logic [`CMD_OFS_W-1:0] wr_ofs;
	logic [BANK_W-1:0] addr_bank;
	logic in_id_bank;
	logic lock_rd;
	logic [ADDR_W-1:0] burst_next;
	logic [ADDR_W-1:0] group_mask;
	logic [2:0] len_code;
	logic wrap_en;

	assign wr_ev = !ce_n && !we_n && we_n_q;
	assign rd_cycle = !ce_n && !oe_n && we_n && addr_valid_n;
	assign wr_cmd = adq_in[7:0];
	assign wr_ofs = addr_q[`CMD_OFS_W-1:0];
	assign addr_bank = addr_q[ADDR_W-1 -: BANK_W];
	assign in_id_bank = id_active_q && (addr_bank == id_bank_q);
	assign len_code = cfg0_q[`CFG0_LEN_HI:`CFG0_LEN_LO];

	sector_lock_table #(
		.SECTOR_W(SECTOR_W)
	) u_lock (
		.clock(clock),
		.reset(reset),
		.wr_en(lock_wr_en),
		.wr_addr(lock_wr_sector),
		.wr_data(lock_wr_value),
		.rd_addr(addr_d[ADDR_W-1 -: SECTOR_W]),
		.rd_data(lock_rd)
	);

	// burst group size and wrap decision
	always_comb begin
		group_mask = '0;
		wrap_en = 1'b0;
		unique case (len_code)
			`LEN_8: begin
				group_mask = ADDR_W'(7);
			end
			`LEN_16: begin
				group_mask = ADDR_W'(15);
			end
			`LEN_32: begin
				group_mask = ADDR_W'(31);
			end
			default: begin
				group_mask = '0;
			end
		endcase
		// continuous or reserved length never wraps
		wrap_en = cfg0_q[`CFG0_WRAP_BIT] && (group_mask != '0);
		if (wrap_en) begin
			burst_next = (addr_q & ~group_mask) | ((addr_q + ADDR_W'(1)) & group_mask);
		end else begin
			burst_next = addr_q + ADDR_W'(1);
		end
	end

	// address capture and burst advance
	always_comb begin
		addr_d = addr_q;
		if (!ce_n && !addr_valid_n) begin
			addr_d = {addr_hi, adq_in};
		end else if (rd_cycle && !in_id_bank && !cfg_read_q) begin
			addr_d = burst_next;
		end
	end

	// read data selection
	always_comb begin
		adq_out_d = adq_out_q;
		adq_oe_n_d = !rd_cycle;
		if (rd_cycle) begin
			if (cfg_read_q) begin
				unique case (addr_q[`ID_OFS_W-1:0])
					`CFG_OFS_ZERO: adq_out_d = cfg0_q;
					`CFG_OFS_ONE: adq_out_d = cfg1_q;
					default: adq_out_d = array_rdata;
				endcase
			end else if (in_id_bank) begin
				// single words only, the address does not advance
				unique case (addr_q[`ID_OFS_W-1:0])
					`ID_OFS_MAKER: adq_out_d = MAKER_CODE;
					`ID_OFS_PART_A: adq_out_d = PART_CODE_A;
					`ID_OFS_PART_B: adq_out_d = PART_CODE_B;
					`ID_OFS_PART_C: adq_out_d = PART_CODE_C;
					`ID_OFS_LOCK: adq_out_d = {15'h0000, lock_rd};
					`ID_OFS_INDICATOR: begin
						adq_out_d = {8'h00, factory_lock, customer_lock,
							`HANDSHAKE_STD, `WP_BOOT_TOP, 3'h0};
					end
					default: adq_out_d = 16'h0000;
				endcase
			end else begin
				adq_out_d = array_rdata;
			end
		end
	end

	// command decode
	always_comb begin
		state_d = state_q;
		id_active_d = id_active_q;
		id_bank_d = id_bank_q;
		cfg_read_d = cfg_read_q;
		cfg0_d = cfg0_q;
		cfg1_d = cfg1_q;
		if (wr_ev) begin
			if ((state_q == flash_id_pkg::CMD_IDLE) && (wr_cmd == `CMD_DATA_RESET)) begin
				id_active_d = 1'b0;
				cfg_read_d = 1'b0;
			end else begin
				unique case (state_q)
					flash_id_pkg::CMD_IDLE: begin
						if (wr_cmd == `CMD_DATA_UNLOCK_A && wr_ofs == `CMD_OFS_UNLOCK_A) begin
							state_d = flash_id_pkg::CMD_UNLOCK1;
						end
					end
					flash_id_pkg::CMD_UNLOCK1: begin
						if (wr_cmd == `CMD_DATA_UNLOCK_B && wr_ofs == `CMD_OFS_UNLOCK_B) begin
							state_d = flash_id_pkg::CMD_UNLOCK2;
						end else begin
							state_d = flash_id_pkg::CMD_IDLE;
						end
					end
					flash_id_pkg::CMD_UNLOCK2: begin
						state_d = flash_id_pkg::CMD_IDLE;
						if (wr_ofs == `CMD_OFS_UNLOCK_A) begin
							if (wr_cmd == `CMD_DATA_ID_ENTRY && !embedded_busy) begin
								id_active_d = 1'b1;
								id_bank_d = addr_bank;
							end else if (wr_cmd == `CMD_DATA_CFG_READ) begin
								cfg_read_d = 1'b1;
							end else if (wr_cmd == `CMD_DATA_CFG_LOAD) begin
								state_d = flash_id_pkg::CMD_CFG0;
							end
						end
					end
					flash_id_pkg::CMD_CFG0: begin
						cfg0_d = adq_in;
						state_d = flash_id_pkg::CMD_CFG1;
					end
					flash_id_pkg::CMD_CFG1: begin
						cfg1_d = adq_in;
						state_d = flash_id_pkg::CMD_IDLE;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state_q <= flash_id_pkg::CMD_IDLE;
			id_active_q <= 1'b0;
			id_bank_q <= '0;
			cfg_read_q <= 1'b0;
			cfg0_q <= `CFG0_RESET;
			cfg1_q <= `CFG1_RESET;
			we_n_q <= 1'b1;
		end else begin
			state_q <= state_d;
			id_active_q <= id_active_d;
			id_bank_q <= id_bank_d;
			cfg_read_q <= cfg_read_d;
			cfg0_q <= cfg0_d;
			cfg1_q <= cfg1_d;
			we_n_q <= we_n;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			addr_q <= '0;
			adq_out_q <= 16'h0000;
			adq_oe_n_q <= 1'b1;
		end else begin
			addr_q <= addr_d;
			adq_out_q <= adq_out_d;
			adq_oe_n_q <= adq_oe_n_d;
		end
	end

	assign adq_out = adq_out_q;
	assign adq_oe_n = adq_oe_n_q;
	assign array_addr = addr_q;
	assign id_mode = id_active_q;
	assign id_bank = id_bank_q;
	assign cfg_read_mode = cfg_read_q;
	assign config_word_zero = cfg0_q;
	assign config_word_one = cfg1_q;

endmodule : flash_id_mode_and_burst_config

`default_nettype wire

// ==== hw/flash_id_params.svh ====
// constants for the identification mode and burst configuration block
// assumes word addressing, 16-bit data and a four-bit bank field at the top of the address
`ifndef FLASH_ID_PARAMS_SVH
`define FLASH_ID_PARAMS_SVH

// command cycle offsets and data
`define CMD_OFS_W 12
`define CMD_OFS_UNLOCK_A 12'h555
`define CMD_OFS_UNLOCK_B 12'h2aa
`define CMD_DATA_UNLOCK_A 8'haa
`define CMD_DATA_UNLOCK_B 8'h55
`define CMD_DATA_ID_ENTRY 8'h90
`define CMD_DATA_RESET 8'hf0
`define CMD_DATA_CFG_LOAD 8'hd0
`define CMD_DATA_CFG_READ 8'hc6

// identification word offsets within a bank
`define ID_OFS_W 8
`define ID_OFS_MAKER 8'h00
`define ID_OFS_PART_A 8'h01
`define ID_OFS_LOCK 8'h02
`define ID_OFS_INDICATOR 8'h07
`define ID_OFS_PART_B 8'h0e
`define ID_OFS_PART_C 8'h0f

// configuration read-back offsets
`define CFG_OFS_ZERO 8'h00
`define CFG_OFS_ONE 8'h01

// configuration word defaults and fields
`define CFG0_RESET 16'h0408
`define CFG1_RESET 16'hffef
`define CFG0_WRAP_BIT 3
`define CFG0_LEN_HI 2
`define CFG0_LEN_LO 0

// burst length codes
`define LEN_CONT 3'h0
`define LEN_8 3'h2
`define LEN_16 3'h3
`define LEN_32 3'h4

// indicator word fields
`define WP_BOOT_TOP 2'h1
`define HANDSHAKE_STD 1'h0

`endif

// ==== hw/flash_id_pkg.sv ====
// types shared by the identification mode and burst configuration block
// assumes nothing beyond a SystemVerilog compiler
package flash_id_pkg;

	typedef enum logic [4:0] {
		CMD_IDLE = 5'h01,
		CMD_UNLOCK1 = 5'h02,
		CMD_UNLOCK2 = 5'h04,
		CMD_CFG0 = 5'h08,
		CMD_CFG1 = 5'h10
	} cmd_state_t;

endpackage : flash_id_pkg

// ==== hw/sector_lock_table.sv ====
// lock flag per sector, one write port and one registered read port
// assumes the program/erase engine writes it on the same clock
`timescale 1ns/1ps
`default_nettype none

module sector_lock_table #(
	parameter int SECTOR_W = 8
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic wr_en,
	input wire logic [SECTOR_W-1:0] wr_addr,
	input wire logic wr_data,
	input wire logic [SECTOR_W-1:0] rd_addr,
	output logic rd_data
);

	logic [(1<<SECTOR_W)-1:0] lock_q;
	logic [(1<<SECTOR_W)-1:0] lock_d;
	logic rd_data_d;

	always_comb begin
		lock_d = lock_q;
		if (wr_en) begin
			lock_d[wr_addr] = wr_data;
		end
		rd_data_d = lock_q[rd_addr];
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			lock_q <= '0;
			rd_data <= 1'b0;
		end else begin
			lock_q <= lock_d;
			rd_data <= rd_data_d;
		end
	end

endmodule : sector_lock_table

`default_nettype wire

// ==== verification/flash_host_model.sv ====
// host controller model: address, write, read and command cycles
// assumes the device samples strobes on the rising clock edge
`timescale 1ns/1ps
`default_nettype none

module flash_host_model (
	input wire logic clock,
	output logic addr_valid_n,
	output logic ce_n,
	output logic we_n,
	output logic oe_n,
	output logic [7:0] addr_hi,
	output logic [15:0] adq_in,
	input wire logic [15:0] adq_out
);
	initial begin
		addr_valid_n = 1'b1;
		ce_n = 1'b1;
		we_n = 1'b1;
		oe_n = 1'b1;
		{addr_hi, adq_in} = 24'h000000;
	end
	task automatic wr(input logic [23:0] a, input logic [15:0] d);
		@(posedge clock);
		ce_n <= 1'b0;
		addr_valid_n <= 1'b0;
		{addr_hi, adq_in} <= a;
		@(posedge clock);
		addr_valid_n <= 1'b1;
		we_n <= 1'b0;
		adq_in <= d;
		@(posedge clock);
		we_n <= 1'b1;
		adq_in <= ~d;
	endtask : wr
	task automatic rd(input logic [23:0] a, output logic [15:0] d);
		@(posedge clock);
		ce_n <= 1'b0;
		addr_valid_n <= 1'b0;
		{addr_hi, adq_in} <= a;
		@(posedge clock);
		addr_valid_n <= 1'b1;
		oe_n <= 1'b0;
		adq_in <= ~a[15:0];
		@(posedge clock);
		oe_n <= 1'b1;
		#1 d = adq_out;
	endtask : rd
	task automatic cmd(input logic [3:0] b, input logic [7:0] c);
		wr({b, 20'h00555}, 16'h00aa);
		wr({b, 20'h002aa}, 16'h0055);
		wr({b, 20'h00555}, {8'h00, c});
	endtask : cmd
endmodule : flash_host_model

`default_nettype wire

// ==== verification/flash_id_checker.sv ====
// port checker for the identification and burst block
// assumes it is bound into the top module and sees its ports only
`timescale 1ns/1ps
`default_nettype none

module flash_id_checker #(
	parameter int ADDR_W = 24,
	parameter int BANK_W = 4,
	parameter logic [15:0] MAKER_CODE = 16'h00a5
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic addr_valid_n,
	input wire logic ce_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic [ADDR_W-17:0] addr_hi,
	input wire logic [15:0] adq_in,
	input wire logic [15:0] adq_out,
	input wire logic [ADDR_W-1:0] array_addr,
	input wire logic embedded_busy,
	input wire logic factory_lock,
	input wire logic customer_lock,
	input wire logic id_mode,
	input wire logic [BANK_W-1:0] id_bank,
	input wire logic cfg_read_mode,
	input wire logic [15:0] config_word_zero,
	input wire logic [15:0] config_word_one
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	wire logic rd = !ce_n && !oe_n && we_n && addr_valid_n;
	wire logic idb = id_mode && !cfg_read_mode && array_addr[ADDR_W-1 -: BANK_W] == id_bank;
	wire logic arr = rd && !idb && !cfg_read_mode;
	wire logic [2:0] len = config_word_zero[2:0];
	wire logic cont = len == 3'h0 || len == 3'h1 || len > 3'h4;

	a_addr_latch: assert property (!ce_n && !addr_valid_n
		|=> array_addr == $past({addr_hi, adq_in})) else $error("address not taken");
	a_cfg_default: assert property ($past(reset)
		|-> config_word_one == 16'hffef) else $error("config word one default");
	a_cont_linear: assert property (arr && cont
		|=> array_addr == $past(array_addr) + 1'b1) else $error("continuous step");
	a_wrap_eight: assert property (arr && len == 3'h2 && config_word_zero[3]
		|=> array_addr[2:0] == $past(array_addr[2:0]) + 3'h1
		&& array_addr[ADDR_W-1:3] == $past(array_addr[ADDR_W-1:3])) else $error("wrap step");
	a_no_wrap: assert property (arr && !cont && !config_word_zero[3]
		|=> array_addr == $past(array_addr) + 1'b1) else $error("linear step");
	a_id_enter: assert property ($rose(id_mode)
		|-> !$past(we_n) && $past(adq_in[7:0]) == 8'h90 && !$past(embedded_busy)
		&& $past(array_addr[11:0]) == 12'h555
		&& id_bank == $past(array_addr[ADDR_W-1 -: BANK_W])) else $error("bad id entry");
	a_id_leave: assert property (!$past(reset) && $fell(id_mode)
		|-> !$past(we_n) && $past(adq_in[7:0]) == 8'hf0) else $error("bad id exit");
	a_id_maker: assert property (rd && idb && array_addr[7:0] == 8'h00
		|=> adq_out == MAKER_CODE) else $error("maker word");
	a_indicator_word: assert property (rd && idb && array_addr[7:0] == 8'h07
		|=> adq_out == {8'h00, $past(factory_lock), $past(customer_lock), 1'b0, 2'b01, 3'h0})
		else $error("indicator word");
	a_id_single: assert property (rd && idb
		|=> $stable(array_addr)) else $error("id read advanced");
endmodule : flash_id_checker

bind flash_id_mode_and_burst_config flash_id_checker #(.ADDR_W(ADDR_W), .BANK_W(BANK_W),
	.MAKER_CODE(MAKER_CODE)) i_chk (.*);

`default_nettype wire

// ==== verification/flash_id_mode_and_burst_config_test.sv ====
// self-checking bench for the identification and burst block
// assumes the host model drives the bus and an xor pattern stands for the array
`timescale 1ns/1ps
`default_nettype none

module flash_id_mode_and_burst_config_test;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic embedded_busy = 1'b0;
	logic lock_wr_en = 1'b0;
	logic [7:0] lock_wr_sector = 8'h52;
	logic lock_wr_value = 1'b1;
	logic addr_valid_n, ce_n, we_n, oe_n, adq_oe_n, id_mode, cfg_read_mode;
	logic [7:0] addr_hi;
	logic [15:0] adq_in, adq_out, array_rdata, config_word_zero, config_word_one;
	logic [23:0] array_addr;
	logic [3:0] id_bank;
	int num_errors = 0;
	int cmp_count = 0;

	always #20 clock = ~clock;
	assign array_rdata = array_addr[15:0] ^ 16'h5a5a;

	flash_id_mode_and_burst_config i_dut (.clock(clock), .reset(reset),
		.addr_valid_n(addr_valid_n), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
		.addr_hi(addr_hi), .adq_in(adq_in), .adq_out(adq_out), .adq_oe_n(adq_oe_n),
		.array_addr(array_addr), .array_rdata(array_rdata), .embedded_busy(embedded_busy),
		.factory_lock(1'b1), .customer_lock(1'b0), .lock_wr_en(lock_wr_en),
		.lock_wr_sector(lock_wr_sector), .lock_wr_value(lock_wr_value), .id_mode(id_mode),
		.id_bank(id_bank), .cfg_read_mode(cfg_read_mode),
		.config_word_zero(config_word_zero), .config_word_one(config_word_one));
	flash_host_model i_host (.clock(clock), .addr_valid_n(addr_valid_n), .ce_n(ce_n),
		.we_n(we_n), .oe_n(oe_n), .addr_hi(addr_hi), .adq_in(adq_in), .adq_out(adq_out));

	task automatic check(input string what, input logic [23:0] e, input logic [23:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask : check
	task automatic rd_chk(input logic [23:0] a, input logic [15:0] e);
		logic [15:0] d;
		i_host.rd(a, d);
		check("read word", e, d);
		check("output enable", 1'b0, adq_oe_n);
	endtask : rd_chk
	task automatic test_cfg_read();
		i_host.cmd(4'h0, 8'hc6);
		#1 check("cfg read mode", 1'b1, cfg_read_mode);
		rd_chk(24'h000000, 16'h040f);
		rd_chk(24'h000001, 16'hffef);
		check("config zero", 16'h040f, config_word_zero);
		i_host.wr(24'h000000, 16'h00f0);
		#1 check("cfg read exit", 1'b0, cfg_read_mode);
	endtask : test_cfg_read
	task automatic burst(input logic [15:0] c, input logic [23:0] s, input logic [23:0] n);
		i_host.cmd(4'h0, 8'hd0);
		i_host.wr(24'h0, c);
		i_host.wr(24'h0, 16'hffef);
		rd_chk(s, s[15:0] ^ 16'h5a5a);
		check("next address", n, array_addr);
	endtask : burst
	task automatic test_id();
		@(posedge clock);
		embedded_busy <= 1'b1;
		lock_wr_en <= 1'b1;
		i_host.cmd(4'h3, 8'h90);
		embedded_busy <= 1'b0;
		lock_wr_en <= 1'b0;
		#1 check("busy entry", 1'b0, id_mode);
		i_host.cmd(4'h5, 8'h90);
		#1 check("id bank", {1'b1, 4'h5}, {id_mode, id_bank});
		rd_chk(24'h500000, 16'h00a5);
		rd_chk(24'h500001, 16'h1a2b);
		rd_chk(24'h50000e, 16'h1c2d);
		rd_chk(24'h50000f, 16'h1e00);
		rd_chk(24'h500007, 16'h0088);
		check("id address", 24'h500007, array_addr);
		rd_chk(24'h520002, 16'h0001);
		rd_chk(24'h530002, 16'h0000);
		rd_chk(24'h2000f0, 16'h5aaa);
		i_host.wr(24'h000123, 16'h00f0);
		#1 check("id exit", 1'b0, id_mode);
		rd_chk(24'h500000, 16'h5a5a);
	endtask : test_id
	task automatic complete_run();
		$display("errors %0d comparisons %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : complete_run

	initial begin
		repeat (20000) @(posedge clock);
		num_errors++;
		complete_run();
	end
	initial begin
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		#1 check("config one", 16'hffef, config_word_one);
		test_id();
		burst(16'h0408, 24'h00000f, 24'h000010);
		burst(16'h040a, 24'h00000f, 24'h000008);
		burst(16'h0402, 24'h00000f, 24'h000010);
		burst(16'h040b, 24'h00001f, 24'h000010);
		burst(16'h040c, 24'h00003f, 24'h000020);
		burst(16'h040f, 24'h00003f, 24'h000040);
		test_cfg_read();
		complete_run();
	end
endmodule : flash_id_mode_and_burst_config_test

`default_nettype wire
